/* rtl/qdsu_top.sv */
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// [R1] Frame sync fall enables buffers, arms shifter
// [R2] Capture one bit per falling edge, 32
// [R3] Early frame sync rise discards partial write
// [R4] Host presents data for falling-edge sampling
// [R5] Shift register exactly 32 bits wide
// [R6] Serial clock up to 50 MHz
// [R7] Load strobe low copies new inputs to outputs
// [R8] Load strobe may be tied low permanently
// [R9] Serial out shifts on rising clock edges
// [R10] Clear acts on its falling edge, asynchronously; the code detects the fall synchronously on clk through the clr_s synchroniser
// [R11] Load strobe ignored while clear held low
// [R12] Clear loads input and output registers with code
// [R13] Clear code selects zero after reset
// [R14] Power-on select picks zero or midscale
// [R15] Reference pin is input until internal selected
// [R16] Internal reference off until serial write enables
// [R17] Completed frame decoded once; extra edges ignored
module qdsu_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   sclk,
  input  wire logic                   sync_n,
  input  wire logic                   din,
  input  wire logic                   load_outputs_n,
  input  wire logic                   async_clear_n,
  input  wire logic                   power_on_select,
  output logic                        serial_out,
  output logic                        input_buffers_on,
  output logic                        reference_pin_oe,
  output logic [3:0][15:0]            dac_code,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  // ==========================================================
  // Link domain state
  typedef struct packed {
    logic [31:0] shreg;   // R5
    logic [5:0]  cnt;
    logic [31:0] word;
    logic        tog;
  } qdsu_lk_t;

  qdsu_lk_t lk_reg;
  qdsu_lk_t lk_next;
  logic     armed_reg;
  logic     so_reg;

  // Arm on every frame sync rise; first falling edge of a frame clears it
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      armed_reg <= 1'b1; // R1 R3
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // Shift, count and frame completion
  always_comb begin
    lk_next = lk_reg;
    if (!sync_n) begin
      lk_next.shreg = {lk_reg.shreg[30:0], din}; // R2 R4
      if (armed_reg) begin
        lk_next.cnt = qdsu_pkg::CNT_FIRST; // R3
      end else if (lk_reg.cnt != qdsu_pkg::CNT_IDLE) begin
        lk_next.cnt = lk_reg.cnt + 6'h01;
      end
      if (!armed_reg && lk_reg.cnt == qdsu_pkg::CNT_LAST) begin
        lk_next.word = {lk_reg.shreg[30:0], din}; // R17
        lk_next.tog  = ~lk_reg.tog;
      end
    end
  end

  // Link register, falling-edge sampling
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_reg <= '{shreg: 32'h0000_0000, cnt: qdsu_pkg::CNT_IDLE, word: 32'h0000_0000, tog: 1'b0};
    end else begin
      lk_reg <= lk_next; // R6
    end
  end

  // Serial out launched on the rising edge, stable for the next fall
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      so_reg <= 1'b0;
    end else begin
      so_reg <= lk_reg.shreg[31]; // R9
    end
  end

  assign serial_out = so_reg;

  // ==========================================================
  // System domain state
  typedef struct packed {
    logic [1:0]       tog_s;
    logic             tog_seen;
    logic [1:0]       ld_s;
    logic [1:0]       clr_s;
    logic [1:0]       por_s;
    logic [1:0]       sy_s;
    logic             clr_prev;
    logic             por_done;
    logic             buf_en;
    logic [3:0][15:0] inreg;
    logic [3:0][15:0] dac;
    logic [3:0]       pend;
    logic [1:0]       clr_sel;
    logic             ref_on;
    logic [7:0]       frames;
    logic [31:0]      last_word;
    logic             sw_load;
    logic             aw_have;
    logic [7:0]       aw_addr;
    logic             w_have;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } qdsu_st_t;

  qdsu_st_t  st_reg;
  qdsu_st_t  st_next;
  qdsu_st_t  keep;
  logic        new_frame;
  logic        clr_low;
  logic        clr_fall;
  logic        load_act;
  logic [3:0]  cmd;
  logic [3:0]  adr;
  logic [15:0] wval;
  logic [15:0] clr_code;
  logic [3:0]  sel;
  logic [7:0]  ra;

  // Synchronisers, serial decode, load, clear, power-on and register bus
  always_comb begin
    st_next  = st_reg;
    keep     = st_reg;
    st_next.tog_s = {st_reg.tog_s[0], lk_reg.tog};
    st_next.ld_s  = {st_reg.ld_s[0], load_outputs_n};
    st_next.clr_s = {st_reg.clr_s[0], async_clear_n};
    st_next.por_s = {st_reg.por_s[0], power_on_select};
    st_next.sy_s  = {st_reg.sy_s[0], sync_n};
    st_next.buf_en   = ~st_reg.sy_s[1]; // R1
    st_next.tog_seen = st_reg.tog_s[1];
    st_next.clr_prev = st_reg.clr_s[1];
    st_next.sw_load  = 1'b0;
    new_frame = st_reg.tog_s[1] ^ st_reg.tog_seen;
    clr_low   = ~st_reg.clr_s[1];
    clr_fall  = st_reg.clr_prev & ~st_reg.clr_s[1]; // R10
    load_act  = (~st_reg.ld_s[1] | st_reg.sw_load) & ~clr_low; // R7 R8 R11
    cmd  = lk_reg.word[qdsu_pkg::CMD_MSB:qdsu_pkg::CMD_LSB];
    adr  = lk_reg.word[qdsu_pkg::ADR_MSB:qdsu_pkg::ADR_LSB];
    wval = lk_reg.word[qdsu_pkg::DAT_MSB:qdsu_pkg::DAT_LSB];
    case (st_reg.clr_sel)
      qdsu_pkg::CLR_MID:  clr_code = qdsu_pkg::CODE_MID;
      qdsu_pkg::CLR_FULL: clr_code = qdsu_pkg::CODE_FULL;
      default:            clr_code = qdsu_pkg::CODE_ZERO;
    endcase
    for (int i = 0; i < qdsu_pkg::NUM_CH; i++) begin
      sel[i] = (adr == 4'(i)) | (adr == qdsu_pkg::ADR_ALL);
    end
    ra = 8'h00;

    // Power-on level, taken once after reset release
    if (!st_reg.por_done) begin
      st_next.por_done = 1'b1;
      st_next.inreg = {4{st_reg.por_s[1] ? qdsu_pkg::CODE_MID : qdsu_pkg::CODE_ZERO}}; // R14
      st_next.dac   = {4{st_reg.por_s[1] ? qdsu_pkg::CODE_MID : qdsu_pkg::CODE_ZERO}}; // R14
    end

    // Load strobe copies channels holding new input data
    if (load_act) begin
      for (int i = 0; i < qdsu_pkg::NUM_CH; i++) begin
        if (st_reg.pend[i]) begin
          st_next.dac[i]  = st_reg.inreg[i]; // R7
          st_next.pend[i] = 1'b0;
        end
      end
    end

    // Decode a completed frame once
    if (new_frame) begin
      st_next.last_word = lk_reg.word; // R17
      st_next.frames    = st_reg.frames + 8'h01;
      case (cmd)
        qdsu_pkg::CMD_WR_IN, qdsu_pkg::CMD_WR_UPALL, qdsu_pkg::CMD_WR_UPD: begin
          for (int i = 0; i < qdsu_pkg::NUM_CH; i++) begin
            if (sel[i]) begin
              st_next.inreg[i] = wval;
              st_next.pend[i]  = (cmd == qdsu_pkg::CMD_WR_IN);
              if (cmd == qdsu_pkg::CMD_WR_UPD) begin
                st_next.dac[i] = wval;
              end
            end
          end
          if (cmd == qdsu_pkg::CMD_WR_UPALL) begin
            for (int i = 0; i < qdsu_pkg::NUM_CH; i++) begin
              st_next.dac[i]  = sel[i] ? wval : st_reg.inreg[i];
              st_next.pend[i] = 1'b0;
            end
          end
        end
        qdsu_pkg::CMD_UPD: begin
          for (int i = 0; i < qdsu_pkg::NUM_CH; i++) begin
            if (sel[i]) begin
              st_next.dac[i]  = st_reg.inreg[i];
              st_next.pend[i] = 1'b0;
            end
          end
        end
        qdsu_pkg::CMD_CLR_CODE: st_next.clr_sel = lk_reg.word[1:0];
        qdsu_pkg::CMD_REF:      st_next.ref_on  = lk_reg.word[0]; // R15 R16
        default: ;
      endcase
    end

    // Clear edge overrides load, power-on and frame writes to the input and DAC registers in its cycle
    if (clr_fall) begin
      st_next.inreg = {4{clr_code}}; // R12
      st_next.dac   = {4{clr_code}}; // R12
      st_next.pend  = 4'h0;
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = qdsu_pkg::RESP_SLVERR;
      if (st_reg.aw_addr[7:2] == qdsu_pkg::OFS_CTRL[7:2]) begin
        st_next.bresp = qdsu_pkg::RESP_OKAY;
        if (st_reg.wstrb[0]) begin
          st_next.sw_load = st_reg.wdata[qdsu_pkg::CTRL_SW_LOAD];
          if (st_reg.wdata[qdsu_pkg::CTRL_CNT_CLR]) begin
            st_next.frames = new_frame ? 8'h01 : 8'h00;
          end
        end
      end
    end

    // Read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      ra = 8'(s_axi_araddr);
      st_next.rvalid = 1'b1;
      st_next.rresp  = qdsu_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (ra[7:2] == qdsu_pkg::OFS_STATUS[7:2]) begin
        st_next.rdata[15:0] = {st_reg.frames, st_reg.pend, clr_low, st_reg.ref_on, st_reg.clr_sel};
      end else if (ra[7:2] == qdsu_pkg::OFS_WORD[7:2]) begin
        st_next.rdata = st_reg.last_word;
      end else if (ra[7:2] == qdsu_pkg::OFS_CTRL[7:2]) begin
        st_next.rdata = 32'h0000_0000;
      end else if (ra[7:4] == qdsu_pkg::GRP_DAC) begin
        st_next.rdata[15:0] = st_reg.dac[ra[3:2]];
      end else if (ra[7:4] == qdsu_pkg::GRP_INPUT) begin
        st_next.rdata[15:0] = st_reg.inreg[ra[3:2]];
      end else begin
        st_next.rresp = qdsu_pkg::RESP_SLVERR;
      end
    end
    st_next.awready = ~st_next.aw_have & ~st_next.bvalid;
    st_next.wready  = ~st_next.w_have & ~st_next.bvalid;
    st_next.arready = ~st_next.rvalid;

    // Synchronous reset, synchroniser chains keep running
    if (!rst_n) begin
      keep    = st_next;
      st_next = '0;
      st_next.tog_s    = keep.tog_s;
      st_next.ld_s     = keep.ld_s;
      st_next.clr_s    = keep.clr_s;
      st_next.por_s    = keep.por_s;
      st_next.sy_s     = keep.sy_s;
      st_next.clr_prev = keep.clr_prev; // Tracks the pin, so no false edge after reset
      st_next.tog_seen = keep.tog_seen; // Stale toggle is not decoded after reset
      st_next.clr_sel  = qdsu_pkg::CLR_ZERO; // R13
      st_next.ref_on   = 1'b0; // R16
    end
  end

  // System register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // Outputs straight from flip-flops
  assign input_buffers_on = st_reg.buf_en;
  assign reference_pin_oe = st_reg.ref_on; // R15
  assign dac_code         = st_reg.dac;
  assign s_axi_awready    = st_reg.awready;
  assign s_axi_wready     = st_reg.wready;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_arready    = st_reg.arready;
  assign s_axi_rdata      = st_reg.rdata;
  assign s_axi_rresp      = st_reg.rresp;
  assign s_axi_rvalid     = st_reg.rvalid;

  // ==========================================================
  // Checks, link domain
  sequence s_frame_end;
    !armed_reg && lk_reg.cnt == qdsu_pkg::CNT_LAST && !sync_n;
  endsequence

  a_frame_32_bits: assert property (@(negedge sclk) disable iff (!rst_n) // R2
    $changed(lk_reg.tog) |-> $past(lk_reg.cnt) == qdsu_pkg::CNT_LAST)
    else $error("frame completed at wrong bit count");

  a_frame_done_word: assert property (@(negedge sclk) disable iff (!rst_n) // R5
    s_frame_end |=> lk_reg.word == lk_reg.shreg && lk_reg.cnt == qdsu_pkg::CNT_IDLE)
    else $error("completed word differs from shift register");

  a_frame_rearm: assert property (@(negedge sclk) disable iff (!rst_n) // R3
    armed_reg && !sync_n |=> lk_reg.cnt == qdsu_pkg::CNT_FIRST && $stable(lk_reg.tog))
    else $error("new frame did not restart bit count");

  a_extra_edges: assert property (@(negedge sclk) disable iff (!rst_n) // R17
    !armed_reg && lk_reg.cnt == qdsu_pkg::CNT_IDLE |=> $stable(lk_reg.tog) && $stable(lk_reg.word))
    else $error("edge after completion decoded again");

  a_serial_out: assert property (@(posedge sclk) disable iff (!rst_n) // R9
    $changed(lk_reg.shreg) |=> serial_out == $past(lk_reg.shreg[31]))
    else $error("serial out not launched on rising edge");

  // ==========================================================
  // Checks, system domain
  sequence s_clear_edge;
    st_reg.clr_prev && !st_reg.clr_s[1];
  endsequence

  a_clear_code: assert property (@(posedge clk) disable iff (!rst_n) // R12
    s_clear_edge |=> dac_code == {4{$past(clr_code)}} && st_reg.inreg == {4{$past(clr_code)}})
    else $error("clear did not load clear code");

  a_clear_default: assert property (@(posedge clk) disable iff (!rst_n) // R13
    $rose(rst_n) |-> st_reg.clr_sel == qdsu_pkg::CLR_ZERO && !reference_pin_oe)
    else $error("clear code or reference not default after reset");

  a_load_blocked: assert property (@(posedge clk) disable iff (!rst_n) // R11
    !st_reg.clr_s[1] && st_reg.clr_prev == st_reg.clr_s[1] && !new_frame && st_reg.por_done
      |=> $stable(dac_code))
    else $error("output changed while clear held low");

  a_load_copies: assert property (@(posedge clk) disable iff (!rst_n) // R7
    load_act && st_reg.pend[0] && !clr_fall && !new_frame && st_reg.por_done
      |=> dac_code[0] == $past(st_reg.inreg[0]) && !st_reg.pend[0])
    else $error("load did not copy input register");

  a_power_on: assert property (@(posedge clk) disable iff (!rst_n) // R14
    rst_n && !st_reg.por_done && !clr_fall
      |=> dac_code == {4{($past(st_reg.por_s[1]) ? qdsu_pkg::CODE_MID : qdsu_pkg::CODE_ZERO)}})
    else $error("power-on level wrong");

  a_ref_by_frame: assert property (@(posedge clk) disable iff (!rst_n) // R16
    $rose(reference_pin_oe) |-> $past(new_frame) && $past(cmd) == qdsu_pkg::CMD_REF)
    else $error("reference enabled without serial write");

  a_buffers_on: assert property (@(posedge clk) disable iff (!rst_n) // R1
    st_reg.sy_s[1] ##1 !st_reg.sy_s[1] |=> input_buffers_on)
    else $error("buffers not enabled after frame sync fall");

endmodule // qdsu_top

/* common/qdsu_pkg.sv */
package qdsu_pkg;

  // ==========================================================
  // Serial frame
  localparam int          FRAME_BITS   = 32;
  localparam int          SCLK_MAX_MHZ = 50;
  localparam int          CLK_MHZ      = 50;
  localparam int          CODE_W       = 16;
  localparam int          NUM_CH       = 4;
  localparam logic [5:0]  CNT_IDLE     = 6'h20;
  localparam logic [5:0]  CNT_LAST     = 6'h1F;
  localparam logic [5:0]  CNT_FIRST    = 6'h01;

  // ==========================================================
  // Command word layout
  localparam int          CMD_MSB      = 27;
  localparam int          CMD_LSB      = 24;
  localparam int          ADR_MSB      = 23;
  localparam int          ADR_LSB      = 20;
  localparam int          DAT_MSB      = 19;
  localparam int          DAT_LSB      = 4;
  localparam logic [3:0]  CMD_WR_IN    = 4'h0;
  localparam logic [3:0]  CMD_UPD      = 4'h1;
  localparam logic [3:0]  CMD_WR_UPALL = 4'h2;
  localparam logic [3:0]  CMD_WR_UPD   = 4'h3;
  localparam logic [3:0]  CMD_CLR_CODE = 4'h5;
  localparam logic [3:0]  CMD_REF      = 4'h8;
  localparam logic [3:0]  ADR_ALL      = 4'hF;

  // ==========================================================
  // Codes and clear selection
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_MID     = 16'h8000;
  localparam logic [15:0] CODE_FULL    = 16'hFFFF;
  localparam logic [1:0]  CLR_ZERO     = 2'h0;
  localparam logic [1:0]  CLR_MID      = 2'h1;
  localparam logic [1:0]  CLR_FULL     = 2'h2;

  // ==========================================================
  // Register map and bus answers
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_WORD     = 8'h08;
  localparam logic [3:0]  GRP_DAC      = 4'h1;
  localparam logic [3:0]  GRP_INPUT    = 4'h2;
  localparam int          CTRL_SW_LOAD = 0;
  localparam int          CTRL_CNT_CLR = 1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* sim/qdsu_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Host driving the framed serial write
module qdsu_host (
  output logic      sclk,
  output logic      sync_n,
  output logic      din,
  input  wire logic serial_out
);
  localparam realtime HALF = 62.5; // 8 MHz shift clock, under the ceiling

  // Idle: shift clock parked high, frame sync released; the late rise arms the first frame
  initial begin
    sclk   = 1'b1;
    sync_n = 1'b0;
    din    = 1'b0;
    #5;
    sync_n = 1'b1;
  end

  // One frame of n bits, MSB first; bits seen after the 32nd edge come back in rb
  task automatic send(input logic [63:0] w, input int n, output logic [31:0] rb);
    rb = 32'h0;
    sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      #(HALF);
      if (n - i > 32) rb = {rb[30:0], serial_out};
      sclk = 1'b0;
      #(HALF);
      sclk = 1'b1;
      #1;
    end
    sync_n = 1'b1;
    din = ~din; // Released line shows no stale bit
    #(4 * HALF);
  endtask
endmodule // qdsu_host

/* sim/quad_dac_serial_update_control_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench for the serial update control block
module quad_dac_serial_update_control_tb;
  logic clk = 1'b0, rst_n = 1'b1, load_outputs_n = 1'b1, async_clear_n = 1'b1, power_on_select = 1'b0;
  logic sclk, sync_n, din, serial_out, input_buffers_on, reference_pin_oe;
  logic [3:0][15:0] dac_code;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rb, seed = 32'h0001_111C; // Start value 69916
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] c0, c1, c2, c3, c5;
  logic [33:0] exp_q[$];
  int fail_count = 0, cmp_count = 0, cyc = 0;

  qdsu_top qdsu_top_i (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .din(din),
    .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n), .power_on_select(power_on_select),
    .serial_out(serial_out), .input_buffers_on(input_buffers_on), .reference_pin_oe(reference_pin_oe),
    .dac_code(dac_code), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  qdsu_host qdsu_host_i (.sclk(sclk), .sync_n(sync_n), .din(din), .serial_out(serial_out));

  // Clock and cycle ceiling
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  // Watcher: each bus answer is compared with the oldest note
  always @(posedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("BAD t=%0t unexpected answer seen=%h exp=%h", $time, rdata, 32'h0);
      end
      else if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
      else chk({rresp, rdata}, exp_q.pop_front());
    end
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  function automatic logic [31:0] fw(logic [3:0] cmd, logic [3:0] ch, logic [15:0] code, logic [3:0] lo);
    return {4'h0, cmd, ch, code, lo};
  endfunction

  // Bus cycles: note the expected answer, then run the handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = qdsu_pkg::RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic reset_dut(input logic pos);
    @(posedge clk);
    rst_n <= 1'b0; power_on_select <= pos;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic frame(input logic [63:0] w, input int n);
    qdsu_host_i.send(w, n, rb);
    repeat (10) @(posedge clk);
  endtask

  task automatic pin_pulse(input bit clr);
    @(posedge clk);
    if (clr) async_clear_n <= 1'b0; else load_outputs_n <= 1'b0;
    repeat (4) @(posedge clk);
    async_clear_n <= 1'b1; load_outputs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    reset_dut(1'b1);
    for (int k = 0; k < qdsu_pkg::NUM_CH; k++) chk(34'(dac_code[k]), 34'(qdsu_pkg::CODE_MID));
    reset_dut(1'b0);
    for (int k = 0; k < qdsu_pkg::NUM_CH; k++) chk(34'(dac_code[k]), 34'(qdsu_pkg::CODE_ZERO));
    rd(qdsu_pkg::OFS_STATUS, 32'h0);
    chk(34'(reference_pin_oe), 34'h0);
    c0 = rnd(); c1 = rnd(); c2 = rnd(); c3 = rnd(); c5 = rnd();
    fork
      frame({32'h0, fw(qdsu_pkg::CMD_WR_IN, 4'h1, c0, 4'h0)}, 32);
      begin repeat (30) @(posedge clk); chk(34'(input_buffers_on), 34'h1); end
    join
    chk(34'(input_buffers_on), 34'h0);
    rd(8'h24, {16'h0, c0});
    rd(8'h14, 32'h0);
    rd(qdsu_pkg::OFS_WORD, fw(qdsu_pkg::CMD_WR_IN, 4'h1, c0, 4'h0));
    pin_pulse(1'b0);
    rd(8'h14, {16'h0, c0});
    frame({32'h0, fw(qdsu_pkg::CMD_WR_UPD, 4'h2, c1, 4'h0)} >> 1, 31);
    rd(8'h18, 32'h0);
    rd(qdsu_pkg::OFS_WORD, fw(qdsu_pkg::CMD_WR_IN, 4'h1, c0, 4'h0));
    frame({32'h0, fw(qdsu_pkg::CMD_WR_UPALL, 4'h0, c1, 4'h0)}, 32);
    chk(34'(dac_code[0]), 34'(c1));
    frame({fw(qdsu_pkg::CMD_WR_UPD, 4'h3, c2, 4'h0), fw(qdsu_pkg::CMD_WR_UPD, 4'h3, c3, 4'h0)}, 64);
    chk(34'(rb), 34'(fw(qdsu_pkg::CMD_WR_UPD, 4'h3, c2, 4'h0)));
    chk(34'(dac_code[3]), 34'(c2));
    frame({32'h0, fw(qdsu_pkg::CMD_WR_IN, 4'h2, c3, 4'h0)}, 32);
    frame({32'h0, fw(qdsu_pkg::CMD_UPD, 4'h2, 16'h0, 4'h0)}, 32);
    chk(34'(dac_code[2]), 34'(c3));
    frame({32'h0, fw(qdsu_pkg::CMD_REF, 4'h0, 16'h0, 4'h1)}, 32);
    chk(34'(reference_pin_oe), 34'h1);
    // Every clear selection, the first one from the reset default
    for (int s = 0; s < 4; s++) begin
      if (s > 0) frame({32'h0, fw(qdsu_pkg::CMD_CLR_CODE, 4'h0, 16'h0, 4'(s))}, 32);
      pin_pulse(1'b1);
      c1 = (s == 1) ? qdsu_pkg::CODE_MID : (s == 2) ? qdsu_pkg::CODE_FULL : qdsu_pkg::CODE_ZERO;
      for (int k = 0; k < qdsu_pkg::NUM_CH; k++) chk(34'(dac_code[k]), 34'(c1));
      rd(8'h20, {16'h0, c1});
    end
    // Held clear blocks the load strobe; release lets it through
    @(posedge clk) async_clear_n <= 1'b0;
    frame({32'h0, fw(qdsu_pkg::CMD_WR_IN, 4'h0, c5, 4'h0)}, 32);
    pin_pulse(1'b0);
    chk(34'(dac_code[0]), 34'h0);
    pin_pulse(1'b0);
    chk(34'(dac_code[0]), 34'(c5));
    // Strobe tied low updates straight away
    @(posedge clk) load_outputs_n <= 1'b0;
    frame({32'h0, fw(qdsu_pkg::CMD_WR_IN, 4'h1, c2, 4'h0)}, 32);
    chk(34'(dac_code[1]), 34'(c2));
    @(posedge clk) load_outputs_n <= 1'b1;
    // Software load, refused write and unmapped read
    frame({32'h0, fw(qdsu_pkg::CMD_WR_IN, 4'h3, c0, 4'h0)}, 32);
    wr(qdsu_pkg::OFS_CTRL, 32'h1, qdsu_pkg::RESP_OKAY);
    repeat (8) @(posedge clk);
    chk(34'(dac_code[3]), 34'(c0));
    wr(qdsu_pkg::OFS_STATUS, 32'h3, qdsu_pkg::RESP_SLVERR);
    rd(8'h3C, 32'h0, qdsu_pkg::RESP_SLVERR);
    // Twelve decoded frames, reference on, clear select 3; then the count is cleared
    rd(qdsu_pkg::OFS_STATUS, 32'h0000_0C07);
    wr(qdsu_pkg::OFS_CTRL, 32'h2, qdsu_pkg::RESP_OKAY);
    rd(qdsu_pkg::OFS_STATUS, 32'h0000_0007);
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0) fail_count++;
    stop_test();
  end
endmodule // quad_dac_serial_update_control_tb
